// ### hw/fcbu_branch_unit.sv
// conditional relative branch decision and program counter update
// Summary of operation
// RULE1 - signed greater-or-equal branches only when negative xor overflow is 0.
// RULE2 - signed less-than branches only when negative xor overflow is 1.
// RULE3 - half-carry-set branch adds the offset when half carry is 1, else steps on.
// RULE4 - half-carry-clear branch adds the offset when half carry is 0, else steps on.
// RULE5 - transfer-set branch adds the offset when the transfer bit is 1.
// RULE6 - transfer-clear branch adds the offset when the transfer bit is 0.
// RULE7 - a branch not taken advances the counter by one word and alters no flag.
// RULE8 - not taken costs one cycle, taken two, with a signed word offset.
`timescale 1ns/100ps
module fcbu_branch_unit (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        req_valid,
   input  wire fcbu_pkg::fcbu_req_t         req,
   input  wire fcbu_pkg::fcbu_flags_t       flags,
   output logic                             req_ready,
   output logic                             done,
   output logic                             taken,
   output logic [fcbu_pkg::PC_W-1:0]        program_counter
);
   typedef enum {st_idle, st_jump} fcbu_state_t;

   fcbu_state_t                     state;
   fcbu_state_t                     next_state;
   logic [fcbu_pkg::PC_W-1:0]       next_program_counter;
   logic [fcbu_pkg::PC_W-1:0]       target;
   logic [fcbu_pkg::PC_W-1:0]       next_target;
   logic                            next_done;
   logic                            next_taken;
   logic                            cond;

   // condition test per opcode
   function automatic logic fcbu_cond(input fcbu_pkg::fcbu_op_t op,
                                      input fcbu_pkg::fcbu_flags_t f);
      logic r;
      r = 1'b0;
      case (op)
         fcbu_pkg::fcbu_op_signed_ge:       r = ((f.negative ^ f.overflow) == fcbu_pkg::FLAG_CLR); // RULE1
         fcbu_pkg::fcbu_op_signed_lt:       r = ((f.negative ^ f.overflow) == fcbu_pkg::FLAG_SET); // RULE2
         fcbu_pkg::fcbu_op_halfcarry_set:   r = (f.halfcarry == fcbu_pkg::FLAG_SET); // RULE3
         fcbu_pkg::fcbu_op_halfcarry_clear: r = (f.halfcarry == fcbu_pkg::FLAG_CLR); // RULE4
         fcbu_pkg::fcbu_op_transfer_set:    r = (f.transfer == fcbu_pkg::FLAG_SET); // RULE5
         fcbu_pkg::fcbu_op_transfer_clear:  r = (f.transfer == fcbu_pkg::FLAG_CLR); // RULE6
         default:                           r = 1'b0;
      endcase
      return r;
   endfunction

   assign cond      = fcbu_cond(req.op, flags);
   assign req_ready = (state == st_idle);

   always_comb begin
      next_state           = state;
      next_program_counter = program_counter;
      next_target          = target;
      next_done            = 1'b0;
      next_taken           = taken;
      case (state)
         st_idle: begin
            if (req_valid) begin
               // word offset, sign extended
               next_target = program_counter + fcbu_pkg::PC_STEP
                             + {{(fcbu_pkg::PC_W-fcbu_pkg::OFS_W){req.offset[fcbu_pkg::OFS_W-1]}},
                                req.offset}; // RULE8
               if (cond) begin
                  next_state = st_jump; // RULE8
                  next_taken = 1'b1;
               end else begin
                  next_program_counter = program_counter + fcbu_pkg::PC_STEP; // RULE7
                  next_done            = 1'b1; // RULE8
                  next_taken           = 1'b0;
               end
            end
         end
         st_jump: begin
            next_program_counter = target; // RULE8
            next_done            = 1'b1;
            next_state           = st_idle;
         end
         default: next_state = st_idle;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state           <= st_idle;
         program_counter <= fcbu_pkg::PC_RESET;
         target          <= fcbu_pkg::PC_RESET;
         done            <= 1'b0;
         taken           <= 1'b0;
      end else begin
         state           <= next_state;
         program_counter <= next_program_counter;
         target          <= next_target;
         done            <= next_done;
         taken           <= next_taken;
      end
   end
endmodule

// ### hw/fcbu_pkg.sv
// package for the flag conditional branch unit
package fcbu_pkg;
   localparam int PC_W     = 16;
   localparam int OFS_W    = 7;
   localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
   localparam logic [PC_W-1:0] PC_STEP  = 16'h0001;
   localparam logic             FLAG_SET = 1'b1;
   localparam logic             FLAG_CLR = 1'b0;

   typedef enum logic [2:0] {
      fcbu_op_signed_ge,
      fcbu_op_signed_lt,
      fcbu_op_halfcarry_set,
      fcbu_op_halfcarry_clear,
      fcbu_op_transfer_set,
      fcbu_op_transfer_clear
   } fcbu_op_t;

   typedef struct packed {
      logic negative;
      logic overflow;
      logic halfcarry;
      logic transfer;
   } fcbu_flags_t;

   typedef struct packed {
      fcbu_op_t               op;
      logic signed [OFS_W-1:0] offset;
   } fcbu_req_t;
endpackage

// ### test/fcbu_sva.sv
// checker for the branch unit
`timescale 1ns/100ps
module fcbu_sva (
   input wire logic                        clk,
   input wire logic                        rst,
   input wire logic                        req_valid,
   input wire logic                        req_ready,
   input wire logic                        done,
   input wire logic                        taken,
   input wire fcbu_pkg::fcbu_req_t         req,
   input wire fcbu_pkg::fcbu_flags_t       flags,
   input wire logic [fcbu_pkg::PC_W-1:0]   program_counter
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire a = req_valid && req_ready;
   wire [2:0] o = req.op;
   wire x = o<3'h2 ? flags.negative^flags.overflow : o<3'h4 ? flags.halfcarry : flags.transfer;
   wire c = x ^ (o==3'h0 || o==3'h3 || o==3'h5);
   property p_r1; a && o==3'h0 |=> taken==$past(c); endproperty
   a_r1: assert property (p_r1) else $error("ge");
   property p_r2; a && o==3'h1 |=> taken==$past(c); endproperty
   a_r2: assert property (p_r2) else $error("lt");
   property p_r3; a && o==3'h2 |=> taken==$past(c); endproperty
   a_r3: assert property (p_r3) else $error("hs");
   property p_r4; a && o==3'h3 |=> taken==$past(c); endproperty
   a_r4: assert property (p_r4) else $error("hc");
   property p_r5; a && o==3'h4 |=> taken==$past(c); endproperty
   a_r5: assert property (p_r5) else $error("ts");
   property p_r6; a && o==3'h5 |=> taken==$past(c); endproperty
   a_r6: assert property (p_r6) else $error("tc");
   property p_r7; a ##1 !taken |-> done && program_counter==$past(program_counter)+16'h0001;
   endproperty
   a_r7: assert property (p_r7) else $error("step");
   property p_r8; a ##1 taken |-> !done && !req_ready ##1 done && program_counter==
      $past(program_counter,2)+16'h0001+16'($past(req.offset,2)); endproperty
   a_r8: assert property (p_r8) else $error("jump");
endmodule
bind fcbu_branch_unit fcbu_sva u_sva (.clk, .rst, .req_valid, .req_ready, .done, .taken,
   .req, .flags, .program_counter);

// ### test/tb.sv
// self-checking bench for the branch unit
`timescale 1ns/100ps
`define CHK(n,e,a) cmp_count++; if ((a)!==(e)) begin errors++; $display("ERROR %s %0h %0h",n,e,a); end
module tb;
   logic clk = 0, rst = 1, req_valid = 0, req_ready, done, taken;
   fcbu_pkg::fcbu_req_t req = '0;
   fcbu_pkg::fcbu_flags_t flags = '0;
   logic [15:0] program_counter;
   int errors = 0, cmp_count = 0, pc = 0;
   int exp_q[$];
   always #50 clk = ~clk;
   fcbu_branch_unit u_dut (.clk, .rst, .req_valid, .req, .flags, .req_ready, .done, .taken,
      .program_counter);
   task automatic print_verdict;
      if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk_reset;
      `CHK("pc", 16'h0000, program_counter)
      `CHK("taken", 1'b0, taken)
      `CHK("done", 1'b0, done)
      `CHK("ready", 1'b1, req_ready)
   endtask
   task automatic br(input int o, input int k, input logic [3:0] f);
      logic c;
      int   exp_pc;
      c = (o < 2 ? f[3] ^ f[2] : o < 4 ? f[1] : f[0]) ^ (o == 0 || o == 3 || o == 5);
      pc = (pc + 1 + (c ? k : 0)) & 16'hffff;
      exp_q.push_back(pc);
      req_valid = 1;
      req = {3'(o), 7'(k)};
      flags = f;
      @(negedge clk);
      `CHK("taken", c, taken)
      if (c) begin
         `CHK("ready", 1'b0, req_ready)
         `CHK("done", 1'b0, done)
         @(negedge clk);
      end
      exp_pc = exp_q.pop_front();
      `CHK("done", 1'b1, done)
      `CHK("ready", 1'b1, req_ready)
      `CHK("pc", 16'(exp_pc), program_counter)
   endtask
   initial begin
      void'($urandom(90));
      repeat (11) @(negedge clk);
      chk_reset();
      @(negedge clk);
      rst = 0;
      for (int i = 0; i < 80; i++) br($urandom % 6, $signed(7'($urandom)), 4'($urandom));
      req_valid = 0;
      rst = 1;
      repeat (2) @(negedge clk);
      chk_reset();
      rst = 0;
      pc = 0;
      for (int i = 0; i < 10; i++) br($urandom % 6, $signed(7'($urandom)), 4'($urandom));
      req_valid = 0;
      print_verdict();
   end
   initial begin
      #100us;
      errors++;
      print_verdict();
   end
endmodule
